/* pkg/cprc_pkg.sv */
package cprc_pkg;

    // ----
    // sleep control register
    // ----
    localparam logic [15:0] SLEEP_CTRL_ADDR = 16'hDF3A;
    localparam logic [15:0] SLEEP_CTRL_RST  = 16'h0000;
    localparam int unsigned OSC_PD_BIT      = 0;
    localparam int unsigned LINE_WAKE_BIT   = 1;

    // ----
    // timing
    // ----
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned OSC_WAIT_NS   = 1000;
    localparam int unsigned OSC_WAIT_CYC  = (OSC_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OSC_CNT_W     = 16;

    // ----
    // widths and reset values
    // ----
    localparam int unsigned PRIO_W       = 4;
    localparam int unsigned IRQ_N        = 16;
    localparam logic [3:0]  PIN_SYNC_RST = 4'hF;

    // ----
    // types
    // ----
    typedef enum logic [3:0] {
        ST_RUN        = 4'h0,
        ST_IDLE_DRAIN = 4'h1,
        ST_IDLE       = 4'h3,
        ST_PEC        = 4'h2,
        ST_PD_DRAIN   = 4'h4,
        ST_PDOWN      = 4'h6,
        ST_SLP_DRAIN  = 4'h8,
        ST_SLEEP      = 4'hC,
        ST_OSC_WAIT   = 4'hD
    } cprc_state_t;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cprc_sfr_req_t;

    typedef struct packed {
        logic              peripheral_event_transfer;
        logic [PRIO_W-1:0] prio;
    } cprc_irq_t;

    typedef struct packed {
        logic cpu;
        logic periph;
        logic wdt;
        logic osc;
    } cprc_clk_t;

    localparam cprc_clk_t CLK_ALL_ON = '{cpu: 1'b1, periph: 1'b1, wdt: 1'b1, osc: 1'b1};

endpackage : cprc_pkg

/* src/cprc_osc_wait.sv */
module cprc_osc_wait
    import cprc_pkg::*;
#(
    parameter int unsigned WAIT_CYC = OSC_WAIT_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      done
);

    logic [OSC_CNT_W-1:0] cnt_reg;
    logic [OSC_CNT_W-1:0] cnt_next;
    logic                 busy_reg;
    logic                 busy_next;
    logic                 done_reg;
    logic                 done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start) begin
            busy_next = 1'b1;
            cnt_next  = OSC_CNT_W'(WAIT_CYC - 1);
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - OSC_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

endmodule : cprc_osc_wait

/* src/cprc_ctrl.sv */
// What this block does
// R01 - in idle only the cpu clock stops; bus, peripherals and watchdog run
// R02 - idle starts only after idle instruction and its predecessor completed
// R03 - any reset or pre-enabled interrupt request ends idle, ignoring priority
// R04 - serviceable cpu interrupt enters its routine; otherwise resume after idle
// R05 - serviceable peripheral event transfer runs, then idle continues
// R06 - unserviceable peripheral event transfer ends idle and resumes execution
// R07 - a cpu interrupt request never returns to idle
// R08 - falling nmi edge ends idle and the nmi trap is always taken
// R09 - enabled level 0 request ends idle without vector fetch
// R10 - watchdog runs in idle; overflow raises an internal reset
// R11 - power down stops cpu, peripheral and watchdog clocks; the oscillator clock keeps running
// R12 - only external reset low ends power down; registers reset
// R13 - power down instruction acts only with nmi pin low
// R14 - pending external bus transaction finishes before any low power mode
// R15 - setting oscillator bit enters sleep; wake pin must be high input
// R16 - wake pin or line level detect restarts oscillator and wakes
// R17 - line level detect wakes only when line wake enable is one
// R18 - wake logic uses rising edge of interrupt node 13
// R19 - oscillator bit zero keeps oscillator on, one switches it off
// R20 - sleep wake clears oscillator bit and holds cpu until stable
module cprc_ctrl
    import cprc_pkg::*;
#(
    parameter int unsigned N_IRQ    = IRQ_N,
    parameter int unsigned WAIT_CYC = OSC_WAIT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire cprc_sfr_req_t     sfr_req,
    output logic [15:0]            sfr_rdata,
    input  wire logic              cpu_idle_exec,
    input  wire logic              cpu_power_down_instruction_exec,
    input  wire logic              cpu_prev_done,
    input  wire logic              bus_busy,
    input  wire logic [N_IRQ-1:0]  irq_src,
    input  wire logic [N_IRQ-1:0]  irq_en,
    input  wire cprc_irq_t         irq_sel,
    input  wire logic [PRIO_W-1:0] cpu_prio,
    input  wire logic              global_interrupt_enable,
    input  wire logic              pec_done,
    input  wire logic              wdt_overflow,
    input  wire logic              nmi_b_pin,
    input  wire logic              external_reset_input_b,
    input  wire logic              external_wake_pin,
    input  wire logic              wake_node_irq,
    output cprc_clk_t              clk_en,
    output cprc_state_t            mode,
    output logic                   isr_enter,
    output logic                   nmi_trap,
    output logic                   pec_start,
    output logic                   resume_next,
    output logic                   sys_reset
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] prev_reg;
    logic       nmi_s;
    logic       ext_ok;
    logic       wake_s;
    logic       nmi_fall;
    logic       wake_fall;
    logic       node_rise;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_reg <= PIN_SYNC_RST;
            sync2_reg <= PIN_SYNC_RST;
            prev_reg  <= PIN_SYNC_RST;
        end else begin
            sync1_reg <= {wake_node_irq, external_wake_pin, external_reset_input_b, nmi_b_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign nmi_s     = sync2_reg[0];
    assign ext_ok    = sync2_reg[1];
    assign wake_s    = sync2_reg[2];
    assign nmi_fall  = prev_reg[0] & ~sync2_reg[0];
    assign wake_fall = prev_reg[2] & ~sync2_reg[2];
    assign node_rise = ~prev_reg[3] & sync2_reg[3]; // R18

    // ----------------------------------------------------------------
    // sleep control register
    // ----------------------------------------------------------------
    logic [15:0] sctl_reg;
    logic [15:0] sctl_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        sfr_hit;
    logic        osc_pd;
    logic        line_en;
    logic        wake_clr;

    assign sfr_hit = sfr_req.sel && (sfr_req.addr == SLEEP_CTRL_ADDR);
    assign osc_pd  = sctl_reg[OSC_PD_BIT];
    assign line_en = sctl_reg[LINE_WAKE_BIT];

    always_comb begin
        sctl_next  = sctl_reg;
        rdata_next = 16'h0000;
        if (wake_clr) begin
            sctl_next[OSC_PD_BIT] = 1'b0; // R20
        end
        if (sfr_hit && sfr_req.wr) begin
            sctl_next                = SLEEP_CTRL_RST;
            sctl_next[OSC_PD_BIT]    = sfr_req.wdata[OSC_PD_BIT]; // R19
            sctl_next[LINE_WAKE_BIT] = sfr_req.wdata[LINE_WAKE_BIT];
        end
        if (sfr_hit && !sfr_req.wr) begin
            rdata_next = sctl_reg;
        end
        if (!ext_ok) begin
            sctl_next = SLEEP_CTRL_RST; // R12
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sctl_reg  <= SLEEP_CTRL_RST;
            rdata_reg <= 16'h0000;
        end else begin
            sctl_reg  <= sctl_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // mode sequencer
    // ----------------------------------------------------------------
    cprc_state_t      state_reg;
    cprc_state_t      state_next;
    logic             idle_pend_reg;
    logic             idle_pend_next;
    logic [N_IRQ-1:0] en_lat_reg;
    logic [N_IRQ-1:0] en_lat_next;
    cprc_clk_t        clk_reg;
    cprc_clk_t        clk_next;
    logic             isr_reg;
    logic             isr_next;
    logic             trap_reg;
    logic             trap_next;
    logic             pec_reg;
    logic             pec_next;
    logic             res_reg;
    logic             res_next;
    logic             rst_reg;
    logic             rst_next;
    logic             irq_hit;
    logic             serve;
    logic             idle_go;
    logic             osc_start;
    logic             osc_done;

    assign irq_hit = |(irq_src & en_lat_reg);
    assign serve   = global_interrupt_enable && (irq_sel.prio > cpu_prio);
    assign idle_go = (cpu_idle_exec || idle_pend_reg) && cpu_prev_done;

    always_comb begin
        state_next     = state_reg;
        idle_pend_next = idle_pend_reg;
        en_lat_next    = en_lat_reg;
        isr_next       = 1'b0;
        trap_next      = 1'b0;
        pec_next       = 1'b0;
        res_next       = 1'b0;
        rst_next       = 1'b0;
        wake_clr       = 1'b0;
        osc_start      = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (cpu_idle_exec && !cpu_prev_done) begin
                    idle_pend_next = 1'b1;
                end
                if (idle_go) begin
                    idle_pend_next = 1'b0;
                    state_next     = ST_IDLE_DRAIN; // R02
                end else if (cpu_power_down_instruction_exec && !nmi_s) begin
                    state_next = ST_PD_DRAIN; // R13
                end else if (osc_pd) begin
                    state_next = ST_SLP_DRAIN; // R15
                end
            end
            ST_IDLE_DRAIN: begin
                if (!bus_busy) begin
                    en_lat_next = irq_en;
                    state_next  = ST_IDLE; // R14
                end
            end
            ST_IDLE: begin
                if (nmi_fall) begin
                    trap_next  = 1'b1;
                    state_next = ST_RUN; // R08
                end else if (irq_hit) begin
                    if (irq_sel.peripheral_event_transfer && serve) begin
                        pec_next   = 1'b1;
                        state_next = ST_PEC; // R05
                    end else if (!irq_sel.peripheral_event_transfer && serve && irq_sel.prio != '0) begin
                        isr_next   = 1'b1;
                        state_next = ST_RUN; // R04
                    end else begin
                        res_next   = 1'b1;
                        state_next = ST_RUN; // R06 R07 R09
                    end
                end else if (wdt_overflow) begin
                    rst_next   = 1'b1;
                    state_next = ST_RUN; // R10
                end
            end
            ST_PEC: begin
                if (pec_done) begin
                    state_next = ST_IDLE; // R05
                end
            end
            ST_PD_DRAIN: begin
                if (!bus_busy) begin
                    state_next = ST_PDOWN; // R14
                end
            end
            ST_PDOWN: begin
                state_next = ST_PDOWN; // R12
            end
            ST_SLP_DRAIN: begin
                if (!bus_busy && wake_s) begin
                    state_next = ST_SLEEP; // R14 R15
                end
            end
            ST_SLEEP: begin
                if (wake_fall || (node_rise && line_en)) begin
                    wake_clr   = 1'b1;
                    osc_start  = 1'b1;
                    state_next = ST_OSC_WAIT; // R16 R17
                end
            end
            ST_OSC_WAIT: begin
                if (osc_done) begin
                    res_next   = 1'b1;
                    state_next = ST_RUN; // R20
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (!ext_ok) begin
            state_next     = ST_RUN; // R03 R12
            idle_pend_next = 1'b0;
            rst_next       = 1'b1;
            isr_next       = 1'b0;
            trap_next      = 1'b0;
            pec_next       = 1'b0;
            res_next       = 1'b0;
        end
    end

    always_comb begin
        clk_next = CLK_ALL_ON;
        case (state_next)
            ST_IDLE: begin
                clk_next.cpu = 1'b0; // R01
            end
            ST_PDOWN: begin
                clk_next = '{cpu: 1'b0, periph: 1'b0, wdt: 1'b0, osc: 1'b1}; // R11
            end
            ST_SLEEP: begin
                clk_next = '0; // R15 R19
            end
            ST_OSC_WAIT: begin
                clk_next = '{cpu: 1'b0, periph: 1'b0, wdt: 1'b0, osc: 1'b1}; // R20
            end
            default: begin
                clk_next = CLK_ALL_ON;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg     <= ST_RUN;
            idle_pend_reg <= 1'b0;
            en_lat_reg    <= '0;
            clk_reg       <= CLK_ALL_ON;
            isr_reg       <= 1'b0;
            trap_reg      <= 1'b0;
            pec_reg       <= 1'b0;
            res_reg       <= 1'b0;
            rst_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            idle_pend_reg <= idle_pend_next;
            en_lat_reg    <= en_lat_next;
            clk_reg       <= clk_next;
            isr_reg       <= isr_next;
            trap_reg      <= trap_next;
            pec_reg       <= pec_next;
            res_reg       <= res_next;
            rst_reg       <= rst_next;
        end
    end

    cprc_osc_wait #(
        .WAIT_CYC (WAIT_CYC)
    ) u_osc_wait (
        .clk   (clk),
        .rst_b (rst_b),
        .start (osc_start),
        .done  (osc_done)
    );

    assign sfr_rdata   = rdata_reg;
    assign clk_en      = clk_reg;
    assign mode        = state_reg;
    assign isr_enter   = isr_reg;
    assign nmi_trap    = trap_reg;
    assign pec_start   = pec_reg;
    assign resume_next = res_reg;
    assign sys_reset   = rst_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_idle_quiet;
        state_reg == ST_IDLE && ext_ok && !nmi_fall;
    endsequence

    sequence s_line_wake;
        state_reg == ST_SLEEP && ext_ok && node_rise && line_en;
    endsequence

    a_idle_clocks: assert property (state_reg == ST_IDLE |-> !clk_en.cpu && clk_en.periph && clk_en.wdt) // R01
        else $error("idle clock enables wrong");
    a_idle_entry: assert property ($rose(state_reg == ST_IDLE_DRAIN) |-> $past(cpu_prev_done)) // R02
        else $error("idle entered before predecessor completed");
    a_idle_wake: assert property (s_idle_quiet ##0 irq_hit |=> state_reg != ST_IDLE) // R03
        else $error("enabled request did not end idle");
    a_isr_vector: assert property (s_idle_quiet ##0 irq_hit && !irq_sel.peripheral_event_transfer && serve
                                   |=> isr_enter && state_reg == ST_RUN) // R04
        else $error("serviceable interrupt did not enter routine");
    a_pec_stay: assert property (state_reg == ST_PEC && ext_ok && pec_done |=> state_reg == ST_IDLE) // R05
        else $error("no return to idle after transfer");
    a_pec_reject: assert property (s_idle_quiet ##0 irq_hit && irq_sel.peripheral_event_transfer && !serve
                                   |=> resume_next && state_reg == ST_RUN) // R06
        else $error("rejected transfer did not resume");
    a_no_reidle: assert property (s_idle_quiet ##0 irq_hit && !irq_sel.peripheral_event_transfer
                                  |=> state_reg == ST_RUN [*2]) // R07
        else $error("cpu request returned to idle");
    a_nmi_trap: assert property (state_reg == ST_IDLE && ext_ok && nmi_fall |=> nmi_trap && state_reg == ST_RUN) // R08
        else $error("nmi did not trap");
    a_lvl0_novec: assert property (s_idle_quiet ##0 irq_hit && irq_sel.prio == '0 |=> !isr_enter && resume_next) // R09
        else $error("level 0 request fetched a vector");
    a_wdt_reset: assert property (s_idle_quiet ##0 !irq_hit && wdt_overflow |=> sys_reset) // R10
        else $error("watchdog overflow in idle gave no reset");
    a_pd_clocks: assert property (state_reg == ST_PDOWN |-> !clk_en.cpu && !clk_en.periph && !clk_en.wdt) // R11
        else $error("clock running in power down");
    a_pd_hold: assert property (state_reg == ST_PDOWN && ext_ok |=> state_reg == ST_PDOWN) // R12
        else $error("power down left without reset");
    a_pd_reset: assert property (!ext_ok |=> sys_reset && state_reg == ST_RUN && sctl_reg == SLEEP_CTRL_RST) // R12
        else $error("external reset not applied");
    a_pd_nmi: assert property (state_reg == ST_RUN && ext_ok && cpu_power_down_instruction_exec && nmi_s && !idle_go
                               && !osc_pd |=> state_reg == ST_RUN) // R13
        else $error("power down taken with nmi high");
    a_drain_wait: assert property (state_reg inside {ST_IDLE_DRAIN, ST_PD_DRAIN, ST_SLP_DRAIN} && bus_busy
                                   && ext_ok |=> $stable(state_reg)) // R14
        else $error("low power entered during bus transaction");
    a_sleep_osc: assert property (state_reg == ST_SLEEP |-> !clk_en.osc && osc_pd) // R19
        else $error("oscillator running in sleep");
    a_line_wake: assert property (s_line_wake |=> state_reg == ST_OSC_WAIT && !osc_pd && clk_en.osc) // R16
        else $error("line wake did not restart oscillator");
    a_line_off: assert property (state_reg == ST_SLEEP && ext_ok && node_rise && !line_en && !wake_fall
                                 |=> state_reg == ST_SLEEP) // R17
        else $error("disabled line wake woke the device");
    a_osc_hold: assert property (state_reg == ST_OSC_WAIT |-> !clk_en.cpu) // R20
        else $error("cpu released before oscillator stable");

endmodule : cprc_ctrl

/* verif/cprc_far_end.sv */
module cprc_far_end (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       pec_start,
    input  wire logic [3:0] pec_wait,
    input  wire logic       bus_go,
    input  wire logic [3:0] bus_len,
    output logic            pec_done,
    output logic            bus_busy
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] pec_cnt_reg;
    logic [3:0] bus_cnt_reg;

    always @(posedge clk) begin
        pec_done <= 1'b0;
        if (!rst_b) begin
            pec_cnt_reg <= 4'h0;
            bus_cnt_reg <= 4'h0;
        end else begin
            if (pec_start) begin
                pec_cnt_reg <= 4'(pec_wait + 4'h1);
            end else if (pec_cnt_reg != 4'h0) begin
                pec_cnt_reg <= pec_cnt_reg - 4'h1;
                pec_done    <= (pec_cnt_reg == 4'h1);
            end
            if (bus_go) begin
                bus_cnt_reg <= bus_len;
            end else if (bus_cnt_reg != 4'h0) begin
                bus_cnt_reg <= bus_cnt_reg - 4'h1;
            end
        end
    end

    assign bus_busy = (bus_cnt_reg != 4'h0);
endmodule : cprc_far_end

/* verif/cprc_ctrl_tb_top.sv */
module cprc_ctrl_tb_top;
    import cprc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic          clk, rst_b, idle_x, power_down_instruction_x, prev_done, bus_busy, gie, pec_done, wdt_ovf;
    logic          nmi_b, ext_rst_b, wake_pin, node_irq, bus_go, sys_reset;
    logic          isr_enter, nmi_trap, pec_start, resume_next;
    logic [15:0]   sfr_rdata, irq_src, irq_en;
    logic [3:0]    cpu_prio, bus_len, pec_wait;
    cprc_sfr_req_t sfr_req;
    cprc_irq_t     irq_sel;
    cprc_clk_t     clk_en;
    cprc_state_t   mode;
    int            n_fail, comparisons;
    int            ev[5], base[5];
    string         evn[5] = '{"isr", "nmi", "pec", "resume", "sysrst"};

    cprc_ctrl #(.WAIT_CYC(4)) uut (.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .cpu_idle_exec(idle_x), .cpu_power_down_instruction_exec(power_down_instruction_x), .cpu_prev_done(prev_done), .bus_busy(bus_busy),
        .irq_src(irq_src), .irq_en(irq_en), .irq_sel(irq_sel), .cpu_prio(cpu_prio),
        .global_interrupt_enable(gie), .pec_done(pec_done), .wdt_overflow(wdt_ovf), .nmi_b_pin(nmi_b),
        .external_reset_input_b(ext_rst_b), .external_wake_pin(wake_pin), .wake_node_irq(node_irq),
        .clk_en(clk_en), .mode(mode), .isr_enter(isr_enter), .nmi_trap(nmi_trap), .pec_start(pec_start),
        .resume_next(resume_next), .sys_reset(sys_reset));

    cprc_far_end far (.clk(clk), .rst_b(rst_b), .pec_start(pec_start), .pec_wait(pec_wait),
        .bus_go(bus_go), .bus_len(bus_len), .pec_done(pec_done), .bus_busy(bus_busy));

    always #4 clk = ~clk;

    // ----
    // pulse counters and shared tasks
    // ----
    always @(posedge clk) begin
        if (isr_enter === 1'b1) ev[0]++;
        if (nmi_trap === 1'b1) ev[1]++;
        if (pec_start === 1'b1) ev[2]++;
        if (resume_next === 1'b1) ev[3]++;
        if (sys_reset === 1'b1) ev[4]++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic sfr(input logic wr, input logic [15:0] a, input logic [15:0] wd, output logic [15:0] rd);
        step(1);
        sfr_req = '{sel: 1'b1, wr: wr, addr: a, wdata: wd};
        step(1);
        rd = sfr_rdata;
        sfr_req = '0;
    endtask : sfr

    task automatic wait_mode(input cprc_state_t m, input int n);
        for (int i = 0; i < n && mode !== m; i++) step(1);
        chk("mode", 16'(mode), 16'(m));
    endtask : wait_mode

    task automatic ev_is(input int k, input int exp);
        chk(evn[k], 16'(ev[k] - base[k]), 16'(exp));
    endtask : ev_is

    task automatic go_idle();
        idle_x = 1'b1;
        step(1);
        idle_x = 1'b0;
        wait_mode(ST_IDLE, 12);
        chk("clk_en", 16'(clk_en), 16'h0007);
    endtask : go_idle

    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // ----
    // scenarios
    // ----
    task automatic sc_regs();
        logic [15:0] rd;
        chk("clk_en", 16'(clk_en), 16'h000F);
        sfr(1'b0, SLEEP_CTRL_ADDR, 16'h0000, rd);
        chk("sleep_control", rd, SLEEP_CTRL_RST);
        sfr(1'b1, SLEEP_CTRL_ADDR, 16'hFFFE, rd);
        sfr(1'b0, SLEEP_CTRL_ADDR, 16'h0000, rd);
        chk("sleep_control", rd, 16'h0002);
        sfr(1'b1, 16'hDF3C, 16'h0001, rd);
        sfr(1'b0, 16'hDF3C, 16'h0000, rd);
        chk("unmapped", rd, 16'h0000);
        step(3);
        chk("mode", 16'(mode), 16'(ST_RUN));
        sfr(1'b1, SLEEP_CTRL_ADDR, 16'h0000, rd);
    endtask : sc_regs

    task automatic sc_idle_isr();
        irq_en = 16'h0008;
        irq_sel = '{peripheral_event_transfer: 1'b0, prio: 4'h5};
        prev_done = 1'b0;
        idle_x = 1'b1;
        step(1);
        idle_x = 1'b0;
        step(3);
        chk("mode", 16'(mode), 16'(ST_RUN));
        bus_len = 4'h6;
        bus_go = 1'b1;
        step(1);
        bus_go = 1'b0;
        prev_done = 1'b1;
        wait_mode(ST_IDLE_DRAIN, 4);
        step(2);
        chk("mode", 16'(mode), 16'(ST_IDLE_DRAIN));
        wait_mode(ST_IDLE, 12);
        chk("clk_en", 16'(clk_en), 16'h0007);
        irq_en = 16'h0000;
        base = ev;
        irq_src = 16'h0008;
        wait_mode(ST_RUN, 6);
        step(2);
        irq_src = 16'h0000;
        ev_is(0, 1);
    endtask : sc_idle_isr

    task automatic sc_unserved();
        logic [4:0] tab[3] = '{5'h05, 5'h12, 5'h10};
        for (int k = 0; k < 3; k++) begin
            gie = tab[k][4];
            irq_sel = '{peripheral_event_transfer: 1'b0, prio: tab[k][3:0]};
            irq_en = 16'h0008;
            go_idle();
            base = ev;
            irq_src = 16'h0008;
            wait_mode(ST_RUN, 6);
            step(2);
            irq_src = 16'h0000;
            ev_is(0, 0);
            ev_is(3, 1);
            step(4);
            chk("mode", 16'(mode), 16'(ST_RUN));
        end
    endtask : sc_unserved

    task automatic sc_pec();
        gie = 1'b1;
        irq_sel = '{peripheral_event_transfer: 1'b1, prio: 4'h5};
        go_idle();
        for (int w = 0; w < 8; w += 6) begin
            pec_wait = 4'(w);
            base = ev;
            irq_src = 16'h0008;
            wait_mode(ST_PEC, 6);
            irq_src = 16'h0000;
            wait_mode(ST_IDLE, 14);
            ev_is(2, 1);
        end
        gie = 1'b0;
        base = ev;
        irq_src = 16'h0008;
        wait_mode(ST_RUN, 6);
        step(2);
        irq_src = 16'h0000;
        ev_is(2, 0);
        ev_is(3, 1);
    endtask : sc_pec

    task automatic sc_nmi_wdt();
        irq_en = 16'h0000;
        go_idle();
        base = ev;
        nmi_b = 1'b0;
        wait_mode(ST_RUN, 8);
        step(2);
        ev_is(1, 1);
        nmi_b = 1'b1;
        step(4);
        go_idle();
        base = ev;
        wdt_ovf = 1'b1;
        step(1);
        wdt_ovf = 1'b0;
        wait_mode(ST_RUN, 4);
        step(1);
        ev_is(4, 1);
    endtask : sc_nmi_wdt

    task automatic sc_pdown();
        logic [15:0] rd;
        sfr(1'b1, SLEEP_CTRL_ADDR, 16'h0002, rd);
        power_down_instruction_x = 1'b1;
        step(1);
        power_down_instruction_x = 1'b0;
        step(3);
        chk("mode", 16'(mode), 16'(ST_RUN));
        nmi_b = 1'b0;
        step(4);
        power_down_instruction_x = 1'b1;
        step(1);
        power_down_instruction_x = 1'b0;
        wait_mode(ST_PDOWN, 8);
        chk("clk_en", 16'(clk_en), 16'h0001);
        nmi_b = 1'b1;
        irq_en = 16'h0008;
        irq_src = 16'h0008;
        step(8);
        chk("mode", 16'(mode), 16'(ST_PDOWN));
        irq_src = 16'h0000;
        irq_en = 16'h0000;
        ext_rst_b = 1'b0;
        wait_mode(ST_RUN, 6);
        chk("sys_reset", 16'(sys_reset), 16'h0001);
        ext_rst_b = 1'b1;
        step(5);
        sfr(1'b0, SLEEP_CTRL_ADDR, 16'h0000, rd);
        chk("sleep_control", rd, SLEEP_CTRL_RST);
    endtask : sc_pdown

    task automatic sc_sleep();
        logic [15:0] rd;
        for (int k = 0; k < 2; k++) begin
            sfr(1'b1, SLEEP_CTRL_ADDR, (k == 1) ? 16'h0003 : 16'h0001, rd);
            wait_mode(ST_SLEEP, 8);
            chk("clk_en", 16'(clk_en), 16'h0000);
            node_irq = 1'b1;
            if (k == 0) begin
                step(6);
                chk("mode", 16'(mode), 16'(ST_SLEEP));
                node_irq = 1'b0;
                wake_pin = 1'b0;
            end
            wait_mode(ST_OSC_WAIT, 6);
            chk("osc_cpu", 16'({clk_en.cpu, clk_en.osc}), 16'h0001);
            base = ev;
            wait_mode(ST_RUN, 12);
            step(1);
            ev_is(3, 1);
            node_irq = 1'b0;
            wake_pin = 1'b1;
            step(4);
            sfr(1'b0, SLEEP_CTRL_ADDR, 16'h0000, rd);
            chk("sleep_control", rd, (k == 1) ? 16'h0002 : 16'h0000);
        end
    endtask : sc_sleep

    initial begin
        clk = 1'b0; rst_b = 1'b0; sfr_req = '0; idle_x = 1'b0; power_down_instruction_x = 1'b0; prev_done = 1'b1;
        irq_src = '0; irq_en = '0; irq_sel = '0; cpu_prio = 4'h2; gie = 1'b1; wdt_ovf = 1'b0;
        nmi_b = 1'b1; ext_rst_b = 1'b1; node_irq = 1'b0; bus_go = 1'b0; bus_len = 4'h0; pec_wait = 4'h0;
        wake_pin = 1'b1;
        step(2);
        rst_b = 1'b1;
        step(4);
        sc_regs();
        sc_idle_isr();
        sc_unserved();
        sc_pec();
        sc_nmi_wdt();
        sc_pdown();
        sc_sleep();
        tally_and_finish();
    end

    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule : cprc_ctrl_tb_top
